// [bsl_board.sv]
// Board straps: levels in reset, address traffic after it
`default_nettype none
module bsl_board (
  input  wire logic       clk_i, rst_i,
  input  wire logic [5:0] lvl_i,
  output var  logic [5:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Straps while in reset, then the shared pins toggle as address lines
  always_ff @(posedge clk_i) pin_o <= rst_i ? lvl_i : ~pin_o;
endmodule : bsl_board
`default_nettype wire

// [bsl_boot_strap_latch.sv]
// Boot strap latch: captures boot and memory straps, Wishbone registers
// Summary of operation
// - Sample two boot-select straps in power-on reset, hold as boot method.
// - Sample four memory-config straps in power-on reset as interface default.
// - Config bit 3 sets upper data byte default: 16 or 8 bit bus.
// - Config bits 2:1 set bank-address-0 pin default among four functions.
// - Config bit 0 sets address-zero/bank-one and upper address defaults.
// - Board drives straps in reset; pins used functionally only afterwards.
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`include "bsl_cfg.svh"
`default_nettype none
module bsl_boot_strap_latch
  import bsl_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire logic [`BSL_BOOT_W-1:0]   boot_method_strap_i,
  input  wire logic [`BSL_CFG_W-1:0]    async_mem_config_strap_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [`BSL_ADDR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  output logic      [`BSL_BOOT_W-1:0]   boot_method_o,
  output logic      [`BSL_CFG_W-1:0]    async_mem_config_o,
  output logic                          upper_data_byte_pin_field_o,
  output logic      [1:0]               bank_address_zero_pin_field_o,
  output logic                          address_zero_bank_one_pin_field_o,
  output logic                          upper_address_pins_field_o,
  output logic                          strap_valid_o,
  output logic                          pins_functional_o
);

  // Capture sequencer state; the sampling state lasts until the first enabled edge after reset
  bsl_state_t   state;
  bsl_state_t   next_state;

  // Pin-function defaults, loaded from the straps, rewritable by software
  bsl_pinfunc_t pinfunc;
  bsl_pinfunc_t next_pinfunc;

  // Scratch release bit of the control register, no effect on the pins
  logic         released;
  logic         next_released;

  // Next values of the latch status outputs
  logic         next_strap_valid;
  logic         next_pins_functional;

  // Qualified bus requests, each counted once per access
  logic         hit;
  logic         wr_hit;
  logic         rd_hit;
  logic         wr_low_byte;

  // Next values of the bus answer
  logic         next_ack;
  logic [31:0]  next_rd_data;

  // Decode of the pin-function defaults from a config code
  // Bit 0 feeds both address-width fields, so the two defaults agree; later writes can set them apart
  function automatic bsl_pinfunc_t cfg_to_pf(
    input logic [`BSL_CFG_W-1:0] c
  );
    bsl_pinfunc_t p;
    p.udb   = c[`BSL_CFG_WIDTH_BIT];
    case (c[`BSL_CFG_BA0_HI:`BSL_CFG_BA0_LO])
      2'h0:    p.ba0 = BSL_BA0_BANK;
      2'h1:    p.ba0 = BSL_BA0_A14;
      2'h2:    p.ba0 = BSL_BA0_GIO54;
      default: p.ba0 = BSL_BA0_RSVD;
    endcase
    p.a0ba1 = c[`BSL_CFG_ADDRW_BIT];
    p.uap   = c[`BSL_CFG_ADDRW_BIT];
    return p;
  endfunction : cfg_to_pf

  // Register select: the byte address must match the offset exactly
  // Partial decoding would alias the registers across the address space
  function automatic logic reg_sel(
    input logic [`BSL_ADDR_W-1:0] adr,
    input logic [`BSL_ADDR_W-1:0] ofs
  );
    return (adr == ofs);
  endfunction : reg_sel

  // Strap status word: boot method, config code and the valid flag
  // Unused bits read as zero so later fields can be added safely
  function automatic logic [31:0] strap_word(
    input logic [`BSL_BOOT_W-1:0] boot,
    input logic [`BSL_CFG_W-1:0]  cfg,
    input logic                   valid
  );
    logic [31:0] w;
    w                                    = 32'h0;
    w[`BSL_STRAP_BOOT_LO +: `BSL_BOOT_W] = boot;
    w[`BSL_STRAP_CFG_LO +: `BSL_CFG_W]   = cfg;
    w[`BSL_STRAP_VALID_BIT]              = valid;
    return w;
  endfunction : strap_word

  // Pin-function word: the packed fields sit in the low bits
  // Field order follows the packed struct, top field first
  function automatic logic [31:0] pinfunc_word(
    input bsl_pinfunc_t p
  );
    logic [31:0] w;
    w                = 32'h0;
    w[`BSL_PF_W-1:0] = p;
    return w;
  endfunction : pinfunc_word

  // Control word: only the release bit is implemented
  // All upper bits read as zero
  function automatic logic [31:0] ctrl_word(
    input logic r
  );
    logic [31:0] w;
    w                    = 32'h0;
    w[`BSL_CTRL_RELEASE] = r;
    return w;
  endfunction : ctrl_word

  // A request counts once: cyc and stb high while ack is still low
  assign hit         = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes and reads split; only byte lane 0 carries the write fields
  assign wr_hit      = hit & wb_we_i;
  assign rd_hit      = hit & ~wb_we_i;
  assign wr_low_byte = wr_hit & wb_sel_i[0];

  // Next capture state; the valid flag rises as the latch starts holding
  // An unused code falls back to holding rather than sampling again
  always_comb begin
    next_state       = state;
    next_strap_valid = strap_valid_o;
    case (state)
      BSL_ST_SAMPLE: begin
        next_state       = BSL_ST_HELD;
        next_strap_valid = 1'b1;
      end
      BSL_ST_HELD: begin
        next_state = BSL_ST_HELD;
      end
      default: begin
        next_state = BSL_ST_HELD;
      end
    endcase
  end

  // Shared pins go functional only once the straps are held
  // Until then the board may still be driving the strap levels
  always_comb begin
    next_pins_functional = (state == BSL_ST_HELD);
  end

  // Pin-function write: takes the packed fields from the low byte lane
  // Upper byte lanes carry no fields, so their strobes are ignored
  always_comb begin
    next_pinfunc = pinfunc;
    if (wr_low_byte && reg_sel(wb_adr_i, `BSL_OFS_PINFUNC)) begin
      next_pinfunc = bsl_pinfunc_t'(wb_dat_i[`BSL_PF_W-1:0]);
    end
  end

  // Control write: the release bit is plain scratch storage
  // Boot code may use it to mark that the straps have been consumed
  always_comb begin
    next_released = released;
    if (wr_low_byte && reg_sel(wb_adr_i, `BSL_OFS_CTRL)) begin
      next_released = wb_dat_i[`BSL_CTRL_RELEASE];
    end
  end

  // Bus answer: ack one cycle after the request is taken
  // Unmapped offsets are answered too, so a master never hangs
  always_comb begin
    next_ack = hit;
  end

  // Read data: writes and unmapped offsets answer with zero
  // The strap word is read only; writes to it are dropped
  always_comb begin
    next_rd_data = 32'h0;
    if (rd_hit) begin
      if (reg_sel(wb_adr_i, `BSL_OFS_STRAP)) begin
        next_rd_data = strap_word(boot_method_o, async_mem_config_o,
                                  strap_valid_o);
      end else if (reg_sel(wb_adr_i, `BSL_OFS_PINFUNC)) begin
        next_rd_data = pinfunc_word(pinfunc);
      end else if (reg_sel(wb_adr_i, `BSL_OFS_CTRL)) begin
        next_rd_data = ctrl_word(released);
      end else begin
        next_rd_data = 32'h0;
      end
    end
  end

  // Boot method latch: follows the straps only while reset is high
  // After release the shared pins carry address traffic, so no resample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_method_o <= boot_method_strap_i;
    end
  end

  // Memory config latch: same capture window as the boot method
  // Later writes to the pin-function fields do not touch it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      async_mem_config_o <= async_mem_config_strap_i;
    end
  end

  // Capture state register
  // Reset parks it in the sampling state; ce low freezes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= BSL_ST_SAMPLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Valid flag: low through reset, high from the first enabled edge after
  // Software polls it to learn that the strap word is settled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_valid_o <= 1'b0;
    end else if (ce_i) begin
      strap_valid_o <= next_strap_valid;
    end
  end

  // Pin-function fields: reset default from the straps, then writable
  // Loading every reset edge keeps the default tied to the last level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pinfunc <= cfg_to_pf(async_mem_config_strap_i);
    end else if (ce_i) begin
      pinfunc <= next_pinfunc;
    end
  end

  // Release bit register
  // Reset clears it; only software sets it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      released <= 1'b0;
    end else if (ce_i) begin
      released <= next_released;
    end
  end

  // Functional-use enable of the shared pins, one edge behind the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_functional_o <= 1'b0;
    end else if (ce_i) begin
      pins_functional_o <= next_pins_functional;
    end
  end

  // Registered pin-function outputs, one edge behind the fields
  // Held low in reset so the pads stay quiet while straps are read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upper_data_byte_pin_field_o       <= 1'b0;
      bank_address_zero_pin_field_o     <= 2'h0;
      address_zero_bank_one_pin_field_o <= 1'b0;
      upper_address_pins_field_o        <= 1'b0;
    end else if (ce_i) begin
      upper_data_byte_pin_field_o       <= pinfunc.udb;
      bank_address_zero_pin_field_o     <= pinfunc.ba0;
      address_zero_bank_one_pin_field_o <= pinfunc.a0ba1;
      upper_address_pins_field_o        <= pinfunc.uap;
    end
  end

  // Acknowledge: a one-cycle pulse, dropped in the cycle after it
  // Gating by ack in the request decode stops a second take
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= next_ack;
    end
  end

  // Read data register: valid in the ack cycle only, zero otherwise
  // Clearing it outside the ack cycle keeps stale data off the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      wb_dat_o <= next_rd_data;
    end
  end

endmodule : bsl_boot_strap_latch
`default_nettype wire

// [bsl_cfg.svh]
// Constants for the boot strap latch: register offsets, fields, widths
`ifndef BSL_CFG_SVH
`define BSL_CFG_SVH
`define BSL_ADDR_W          4
`define BSL_OFS_STRAP       4'h0
`define BSL_OFS_PINFUNC     4'h4
`define BSL_OFS_CTRL        4'h8
`define BSL_BOOT_W          2
`define BSL_CFG_W           4
`define BSL_CFG_WIDTH_BIT   3
`define BSL_CFG_BA0_HI      2
`define BSL_CFG_BA0_LO      1
`define BSL_CFG_ADDRW_BIT   0
`define BSL_PF_UDB_BIT      0
`define BSL_PF_BA0_LO       1
`define BSL_PF_BA0_HI       2
`define BSL_PF_A0BA1_BIT    3
`define BSL_PF_UAP_BIT      4
`define BSL_PF_W            5
`define BSL_CTRL_RELEASE    0
`define BSL_STRAP_BOOT_LO   0
`define BSL_STRAP_CFG_LO    8
`define BSL_STRAP_VALID_BIT 16
`endif

// [bsl_latch_props.sv]
// Checker: strap capture, pin field defaults and late pin use
`default_nettype none
module bsl_latch_props (
  input wire logic       clk_i, rst_i, upper_data_byte_pin_field_o,
  input wire logic       address_zero_bank_one_pin_field_o,
  input wire logic       upper_address_pins_field_o, pins_functional_o,
  input wire logic [1:0] boot_method_strap_i, boot_method_o,
  input wire logic [1:0] bank_address_zero_pin_field_o,
  input wire logic [3:0] async_mem_config_strap_i, async_mem_config_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_boot_latch: assert property ($fell(rst_i) |->
    boot_method_o == $past(boot_method_strap_i)) else $error("boot");
  a_cfg_latch: assert property ($fell(rst_i) |->
    async_mem_config_o == $past(async_mem_config_strap_i)) else $error("cfg");
  a_width_default: assert property ($fell(rst_i) |=>
    upper_data_byte_pin_field_o == async_mem_config_o[3]) else $error("w");
  a_bank_default: assert property ($fell(rst_i) |=>
    bank_address_zero_pin_field_o == async_mem_config_o[2:1])
    else $error("ba0");
  a_addr_default: assert property ($fell(rst_i) |=>
    address_zero_bank_one_pin_field_o == async_mem_config_o[0] &&
    upper_address_pins_field_o == async_mem_config_o[0]) else $error("a");
  a_pins_late: assert property ($fell(rst_i) |->
    !pins_functional_o ##1 !pins_functional_o ##1 pins_functional_o)
    else $error("pins");
  a_strap_hold: assert property (!$fell(rst_i) |->
    $stable({boot_method_o, async_mem_config_o})) else $error("hold");
endmodule : bsl_latch_props
`default_nettype wire

// [bsl_pkg.sv]
// Types for the boot strap latch
`default_nettype none
package bsl_pkg;
  typedef enum logic [1:0] {
    BSL_BA0_BANK  = 2'h0,
    BSL_BA0_A14   = 2'h1,
    BSL_BA0_GIO54 = 2'h2,
    BSL_BA0_RSVD  = 2'h3
  } bsl_ba0_t;
  typedef struct packed {
    logic       uap;
    logic       a0ba1;
    bsl_ba0_t   ba0;
    logic       udb;
  } bsl_pinfunc_t;
  typedef enum logic [1:0] {
    BSL_ST_RESET = 2'b00,
    BSL_ST_SAMPLE = 2'b01,
    BSL_ST_HELD  = 2'b11
  } bsl_state_t;
endpackage : bsl_pkg
`default_nettype wire

// [test_boot_strap_latch.sv]
// Testbench for the boot strap latch
`default_nettype none
module test_boot_strap_latch;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, pf;
  logic [3:0]  adr = 0;
  logic [5:0]  lvl = 0, pin;
  logic [31:0] wd = 0, rd, q;
  wire logic [4:0] fld;
  wire logic [6:0] lat;
  int          err_count = 0, n_compared = 0;
  always #50 clk_i = ~clk_i; // 100 ns clock
  bsl_board brd_u (.clk_i, .rst_i, .lvl_i(lvl), .pin_o(pin));
  bsl_boot_strap_latch dut_u (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc),
    .boot_method_strap_i(pin[5:4]), .async_mem_config_strap_i(pin[3:0]),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .boot_method_o(lat[5:4]),
    .async_mem_config_o(lat[3:0]), .upper_data_byte_pin_field_o(fld[0]),
    .bank_address_zero_pin_field_o(fld[2:1]), .strap_valid_o(lat[6]),
    .address_zero_bank_one_pin_field_o(fld[3]), .pins_functional_o(pf),
    .upper_address_pins_field_o(fld[4]));
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) err_count++;
    if (g !== e) $display("Error at %0t: %h vs %h", $time, g, e);
  endtask : chk
  task automatic wb(input logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clk_i);
    {cyc, we, adr, wd} <= {1'b1, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rd;
    cyc <= 0;
  endtask : wb
  task automatic t_straps();
    for (int i = 0; i < 16; i++) begin
      {rst_i, lvl} <= {1'b1, ~i[1:0], i[3:0]};
      repeat (16) @(posedge clk_i);
      chk({lat[6], pf}, 2'b00);
      rst_i <= 0;
      repeat (4) @(posedge clk_i);
      chk({pf, fld}, {1'b1, i[0], i[0], i[2:1], i[3]});
      chk(lat, {1'b1, ~i[1:0], i[3:0]});
      wb(0, 4'h0, 0);
      chk(q, {5'h10, i[3:0], 6'h00, ~i[1:0]});
    end
  endtask : t_straps
  task automatic t_regs();
    for (int v = 0; v < 32; v += 5) begin
      wb(1, 4'h4, v);
      wb(0, 4'h4, 0);
      chk({q[4:0], fld}, {v[4:0], v[4:0]});
    end
    wb(1, 4'h0, 32'hFFFFFFFF);
    wb(0, 4'hC, 0);
    chk(q, 32'h00000000);
    wb(0, 4'h0, 0);
    chk(q, 32'h00010F00);
    wb(0, 4'h8, 0);
    chk(q, 32'h00000000);
    wb(1, 4'h8, 1);
    wb(0, 4'h8, 0);
    chk(q, 32'h00000001);
  endtask : t_regs
  task automatic print_verdict();
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    t_straps();
    t_regs();
    print_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #200000 err_count++;
    print_verdict();
  end
endmodule : test_boot_strap_latch
bind bsl_boot_strap_latch bsl_latch_props chk_u (.*);
`default_nettype wire
